// ---- sadc_analog_model.sv ----
// Comparator and four analog inputs facing the converter control
`timescale 1ns/1ps
`default_nettype none
module sadc_analog_model (
  input  wire logic            clk_i,
  input  wire logic [3:0][7:0] vin_i,
  input  wire logic [1:0]      chan_i,
  input  wire logic [7:0]      dac_i,
  input  wire logic            supply_i,
  output logic                 comp_o
);
  // ==========================================================
  // Comparator
  logic junk_q = 1'b0;
  // Unpowered comparator output wanders every cycle
  always_ff @(posedge clk_i) begin
    junk_q <= ~junk_q;
  end
  // One when selected input is above the DAC level
  assign comp_o = supply_i ? (vin_i[chan_i] > dac_i) : junk_q;
endmodule
`default_nettype wire

// ---- sadc_ctrl.sv ----
// Successive-approximation converter control with APB registers
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "sadc_map.svh"
module sadc_ctrl
  import sadc_pkg::*;
#(
  parameter int STEPS = 8
) (
  input  wire logic        clk_i,
  input  wire logic        nrst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  input  wire logic        halt_i,
  input  wire logic        stop_i,
  input  wire logic        comp_i,
  output logic      [7:0]  dac_code_o,
  output logic      [1:0]  analog_input_channel_o,
  output logic             sample_o,
  output logic             converter_reference_supply_o,
  output logic             irq_o
);
  // ========================================================================
  // Timing
  localparam int SAMPLE_CYC = `SADC_SAMPLE_CC;
  localparam int STEP_CYC   = `SADC_STEP_CC;

  sadc_state_e state_q;
  sadc_cfg_s   cfg_q;
  logic [7:0]  sar_data_register_q;
  logic [7:0]  trial_q;
  logic [2:0]  bit_q;
  logic [5:0]  cnt_q;
  logic        conversion_done_flag_q;
  logic        compare_result_flag_q;
  logic        supply_q;
  logic [1:0]  irq_st_q;
  logic [1:0]  irq_mask_q;
  logic        ev_done;
  logic        ev_cmp;

  // ========================================================================
  // APB decode
  logic wr_en;
  logic rd_sel;
  logic start_wr;
  logic data_wr;
  logic addr_ok;
  assign wr_en  = psel_i && penable_i && pwrite_i;
  assign rd_sel = psel_i && !pwrite_i;
  assign addr_ok = (paddr_i == `SADC_CTRL_OFS) ||
                   (paddr_i == `SADC_DATA_OFS) ||
                   (paddr_i == `SADC_STAT_OFS) ||
                   (paddr_i == `SADC_IRQ_OFS)  ||
                   (paddr_i == `SADC_MASK_OFS);
  assign pready_o  = 1'b1;
  assign pslverr_o = psel_i && penable_i && !addr_ok;
  assign start_wr = wr_en && (paddr_i == `SADC_CTRL_OFS) &&
                    pwdata_i[`SADC_CTRL_START] && !stop_i;
  // Writes ignored in continuous mode
  assign data_wr  = wr_en && (paddr_i == `SADC_DATA_OFS) &&
                    cfg_q.mode && !stop_i;

  // Read data register
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (rd_sel && !penable_i) begin
      unique case (paddr_i)
        `SADC_CTRL_OFS: prdata_o <= {28'h0000000, cfg_q.chan, cfg_q.mode,
                                     1'b0};
        `SADC_DATA_OFS: prdata_o <= {24'h000000, sar_data_register_q};
        `SADC_STAT_OFS: prdata_o <= {28'h0000000, supply_q,
                                     state_q != SADC_IDLE,
                                     compare_result_flag_q,
                                     conversion_done_flag_q};
        `SADC_IRQ_OFS:  prdata_o <= {30'h00000000, irq_st_q};
        `SADC_MASK_OFS: prdata_o <= {30'h00000000, irq_mask_q};
        default:        prdata_o <= 32'h0000_0000;
      endcase
    end
  end

  // Mode and channel configuration
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cfg_q <= '0;
    end else if (wr_en && paddr_i == `SADC_CTRL_OFS) begin
      cfg_q.mode <= pwdata_i[`SADC_CTRL_MODE];
      cfg_q.chan <= pwdata_i[`SADC_CTRL_CHHI:`SADC_CTRL_CHLO];
    end
  end

  // ========================================================================
  // Sequencer: sample for 14 cycles, settle to a 48-cycle step
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      state_q <= SADC_IDLE;
      cnt_q   <= 6'd0;
      bit_q   <= 3'd0;
    end else if (stop_i) begin
      state_q <= SADC_IDLE;
      cnt_q   <= 6'd0;
      bit_q   <= 3'd0;
    end else if (start_wr || data_wr) begin
      state_q <= SADC_SAMPLE;
      cnt_q   <= 6'd0;
      bit_q   <= 3'(STEPS - 1);
    end else if (!halt_i) begin
      unique case (state_q)
        SADC_IDLE: begin
          cnt_q <= 6'd0;
        end
        SADC_SAMPLE: begin
          cnt_q <= cnt_q + 6'd1;
          if (cnt_q == 6'(SAMPLE_CYC - 1)) begin
            state_q <= SADC_SETTLE;
          end
        end
        SADC_SETTLE: begin
          cnt_q <= cnt_q + 6'd1;
          if (cnt_q == 6'(STEP_CYC - 1)) begin
            cnt_q <= 6'd0;
            if (cfg_q.mode || bit_q == 3'd0) begin
              state_q <= SADC_IDLE;
            end else begin
              state_q <= SADC_SAMPLE;
              bit_q   <= bit_q - 3'd1;
            end
          end
        end
      endcase
    end
  end

  // Decision taken at the end of sampling
  logic decide;
  assign decide = !stop_i && !halt_i && !start_wr && !data_wr &&
                  state_q == SADC_SAMPLE &&
                  cnt_q == 6'(SAMPLE_CYC - 1);
  assign ev_done = !stop_i && !halt_i && !start_wr && !data_wr &&
                   state_q == SADC_SETTLE &&
                   cnt_q == 6'(STEP_CYC - 1) &&
                   (cfg_q.mode || bit_q == 3'd0);
  assign ev_cmp  = decide && cfg_q.mode;

  // Data register: SAR accumulation or software code
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sar_data_register_q <= `SADC_DATA_RST;
    end else if (stop_i) begin
      sar_data_register_q <= `SADC_DATA_RST;
    end else if (data_wr) begin
      sar_data_register_q <= pwdata_i[7:0];
    end else if (start_wr && !pwdata_i[`SADC_CTRL_MODE]) begin
      // New mode decides the clear, so a switch from single mode is clean
      sar_data_register_q <= 8'h00;
    end else if (decide && !cfg_q.mode) begin
      sar_data_register_q[bit_q] <= comp_i;
    end
  end

  // Trial code for the DAC during continuous conversion
  always_comb begin
    trial_q = sar_data_register_q;
    if (!cfg_q.mode && state_q == SADC_SAMPLE) begin
      trial_q[bit_q] = 1'b1;
    end
  end
  // DAC code from flops: SAR trial or written code
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      dac_code_o <= 8'h00;
    end else begin
      dac_code_o <= trial_q;
    end
  end

  // Flags
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      conversion_done_flag_q <= 1'b0;
      compare_result_flag_q  <= 1'b0;
    end else if (stop_i) begin
      conversion_done_flag_q <= 1'b0;
      compare_result_flag_q  <= 1'b0;
    end else begin
      if (start_wr || data_wr) begin
        conversion_done_flag_q <= 1'b0;
      end else if (ev_done) begin
        conversion_done_flag_q <= 1'b1;
      end
      if (ev_cmp) begin
        compare_result_flag_q <= comp_i;
      end
    end
  end

  // Reference supply gate
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      supply_q <= 1'b0;
    end else if (stop_i) begin
      supply_q <= 1'b0;
    end else if (start_wr || data_wr) begin
      supply_q <= 1'b1;
    end else if ((cfg_q.mode && ev_cmp) || (!cfg_q.mode && ev_done)) begin
      supply_q <= 1'b0;
    end
  end

  // Outputs
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      analog_input_channel_o <= 2'b00;
      sample_o               <= 1'b0;
    end else begin
      analog_input_channel_o <= cfg_q.chan;
      sample_o <= (state_q == SADC_SAMPLE) && !stop_i;
    end
  end
  assign converter_reference_supply_o = supply_q;

  // ========================================================================
  // Interrupt status, set wins over write-one-clear
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      irq_st_q   <= 2'b00;
      irq_mask_q <= 2'b00;
    end else begin
      if (wr_en && paddr_i == `SADC_MASK_OFS) begin
        irq_mask_q <= pwdata_i[1:0];
      end
      irq_st_q <= ((wr_en && paddr_i == `SADC_IRQ_OFS) ?
                   (irq_st_q & ~pwdata_i[1:0]) : irq_st_q) |
                  {ev_cmp, ev_done};
    end
  end
  assign irq_o = |(irq_st_q & irq_mask_q);

  // ========================================================================
  // Checks
  // Cycles since a comparison code was written, frozen by halt
  logic [5:0] cmp_age_q;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cmp_age_q <= 6'h00;
    end else if (data_wr) begin
      cmp_age_q <= 6'h01;
    end else if (cfg_q.mode && state_q == SADC_SAMPLE &&
                 cmp_age_q != 6'h00) begin
      if (!halt_i) begin
        cmp_age_q <= cmp_age_q + 6'h01;
      end
    end else begin
      cmp_age_q <= 6'h00;
    end
  end

  // Steps of an operation
  sequence s_start;
    start_wr && !pwdata_i[`SADC_CTRL_MODE];
  endsequence
  sequence s_quiet;
    !stop_i && !halt_i && !start_wr && !data_wr;
  endsequence
  sequence s_data_wr;
    data_wr;
  endsequence

  // Done flag stays low through the first eight cycles of a continuous conversion
  a_done_bound: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    s_start ##1 s_quiet [*8] |-> !conversion_done_flag_q)
    else $error("done flag set too early");

  // Supply rises on start or code write
  a_supply_start: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (start_wr || data_wr) |=> converter_reference_supply_o)
    else $error("supply not on after start");

  // Stop clears the data register and supply and returns the sequencer to idle
  a_stop_clear: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    stop_i |=> sar_data_register_q == 8'h00 && !supply_q &&
      state_q == SADC_IDLE)
    else $error("stop did not initialise");

  // Data writes ignored in continuous mode
  a_ignore_write: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_en && paddr_i == `SADC_DATA_OFS && !cfg_q.mode && state_q ==
     SADC_IDLE && !stop_i && !start_wr) |=> $stable(sar_data_register_q))
    else $error("data write in continuous mode");

  // Halt freezes the sequencer and keeps supply
  a_halt_hold: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (halt_i && !stop_i && !start_wr && !data_wr) |=>
      $stable(cnt_q) && $stable(supply_q))
    else $error("halt did not suspend");

  // Sampling counter after a code write
  a_cmp_time: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (s_data_wr ##1 s_quiet [*8]) |-> state_q == SADC_SAMPLE &&
      cnt_q == 6'h07)
    else $error("sample count wrong");

  // Compare result stored, supply cut
  a_cmp_supply: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    ev_cmp && !stop_i |=> !supply_q &&
      compare_result_flag_q == $past(comp_i))
    else $error("compare result not stored");

  // Done flag set and supply cut at the end
  a_done_supply: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (ev_done && !cfg_q.mode) |=> conversion_done_flag_q && !supply_q)
    else $error("done did not cut supply");

  // Conversion opens on the top bit with a clear register
  a_trial_msb: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    s_start |=> state_q == SADC_SAMPLE && bit_q == 3'h7 &&
      sar_data_register_q == 8'h00)
    else $error("conversion did not start at top bit");

  // Each step moves one bit down
  a_bit_down: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (s_quiet and (state_q == SADC_SETTLE &&
      cnt_q == 6'(STEP_CYC - 1) && !cfg_q.mode && bit_q != 3'h0))
    |=> state_q == SADC_SAMPLE && bit_q == $past(bit_q) - 3'h1)
    else $error("bit order wrong");

  // Single mode ends after one step
  a_single_one: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (s_quiet and (state_q == SADC_SETTLE &&
      cnt_q == 6'(STEP_CYC - 1) && cfg_q.mode)) |=> state_q == SADC_IDLE)
    else $error("single mode ran on");

  // Mode flag follows the control write
  a_mode_write: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (wr_en && paddr_i == `SADC_CTRL_OFS) |=>
      cfg_q.mode == $past(pwdata_i[`SADC_CTRL_MODE]))
    else $error("mode flag not written");

  // Decision lands in the current data bit
  a_decide_store: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (decide && !cfg_q.mode) |=>
      sar_data_register_q[$past(bit_q)] == $past(comp_i))
    else $error("decision not stored");

  // Result flag only moves on a comparison or stop
  a_cmp_hold: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (!ev_cmp && !stop_i) |=> $stable(compare_result_flag_q))
    else $error("result flag changed unprompted");

  // Sampling lasts the sampling count
  a_sample_len: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (s_quiet and (state_q == SADC_SAMPLE &&
      cnt_q == 6'(SAMPLE_CYC - 1))) |=>
      state_q == SADC_SETTLE && cnt_q == 6'(SAMPLE_CYC))
    else $error("sampling length wrong");

  // Step wraps at the step count
  a_step_len: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (s_quiet and (state_q == SADC_SETTLE &&
      cnt_q == 6'(STEP_CYC - 1))) |=> cnt_q == 6'h00)
    else $error("step length wrong");

  // Comparison result lands within the sampling window
  a_cmp_soon: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    cmp_age_q <= 6'h0F)
    else $error("compare result late");

  // Events set their status bits
  a_irq_set: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (ev_done || ev_cmp) |=>
      (irq_st_q & {$past(ev_cmp), $past(ev_done)}) ==
      {$past(ev_cmp), $past(ev_done)})
    else $error("event lost");

  // Start or code write clears the done flag
  a_start_clears: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    (start_wr || data_wr) |=> !conversion_done_flag_q)
    else $error("done flag not cleared");

  // Channel select follows the configuration
  a_chan_follow: assert property (
    @(posedge clk_i) disable iff (!nrst_i)
    1'b1 |=> analog_input_channel_o == $past(cfg_q.chan))
    else $error("channel select wrong");
endmodule
`default_nettype wire

// ---- sadc_ctrl_tb.sv ----
// Self-checking bench for the converter control
`timescale 1ns/1ps
`default_nettype none
`include "sadc_map.svh"
module sadc_ctrl_tb;
  import sadc_pkg::*;
  // ==========================================================
  // Signals
  typedef struct packed {
    logic       mode;
    logic [1:0] chan;
    logic [7:0] vin;
    logic [7:0] code;
    logic [7:0] exp;
  } sadc_row_s;
  logic            clk_i, nrst_i, psel, penable, pwrite, halt, stop;
  logic            comp, pready, pslverr, sample, supply, irq, perr;
  logic [11:0]     paddr;
  logic [31:0]     pwdata, prdata, r;
  logic [7:0]      dac;
  logic [1:0]      chan;
  logic [3:0][7:0] vin;
  int              n_mismatch = 0, samples_checked = 0;
  int              sup_n = 0, smp_n = 0, cyc = 0, s0, m0, d;
  sadc_row_s       rows [0:7] = '{
    '{1'b1, 2'd0, 8'h80, 8'h7F, 8'h01}, '{1'b1, 2'd1, 8'h80, 8'h81, 8'h00},
    '{1'b1, 2'd3, 8'h10, 8'h0F, 8'h01}, '{1'b1, 2'd2, 8'h10, 8'hFF, 8'h00},
    '{1'b0, 2'd1, 8'h01, 8'h00, 8'h00}, '{1'b0, 2'd3, 8'h00, 8'h00, 8'h00},
    '{1'b0, 2'd2, 8'hFF, 8'h00, 8'hFE}, '{1'b0, 2'd0, 8'hA5, 8'h00, 8'hA4}};
  // ==========================================================
  // Design and partner
  sadc_ctrl dut (.clk_i(clk_i), .nrst_i(nrst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr),
    .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .halt_i(halt), .stop_i(stop), .comp_i(comp),
    .dac_code_o(dac), .analog_input_channel_o(chan), .sample_o(sample),
    .converter_reference_supply_o(supply), .irq_o(irq));
  sadc_analog_model ana (.clk_i(clk_i), .vin_i(vin), .chan_i(chan),
    .dac_i(dac), .supply_i(supply), .comp_o(comp));
  // ==========================================================
  // Clock, activity counters and timeout
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (supply === 1'b1) sup_n <= sup_n + 1;
    if (sample === 1'b1) smp_n <= smp_n + 1;
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ==========================================================
  // Tasks
  task automatic summarize();
    if (n_mismatch == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_i);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1) @(posedge clk_i);
    rd      = prdata;
    perr    = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_irq(input int lim);
    int n;
    n = 0;
    while (irq !== 1'b1 && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    chk({31'h0, irq}, 32'h1);
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    {nrst_i, psel, penable, pwrite, halt, stop} = '0;
    paddr  = '0;
    pwdata = '0;
    vin    = '0;
    repeat (16) @(posedge clk_i);
    chk({30'h0, supply, irq}, 32'h0);
    nrst_i <= 1'b1;
    apb(1'b0, `SADC_DATA_OFS, 32'h0, r);
    chk(r, 32'h0);
    apb(1'b0, `SADC_STAT_OFS, 32'h0, r);
    chk(r, 32'h0);
    // Table of conversions and comparisons
    foreach (rows[i]) begin
      vin[rows[i].chan] <= rows[i].vin;
      apb(1'b1, `SADC_MASK_OFS, {30'h0, rows[i].mode, ~rows[i].mode}, r);
      s0 = sup_n;
      m0 = smp_n;
      if (rows[i].mode) begin
        apb(1'b1, `SADC_CTRL_OFS, {28'h0, rows[i].chan, 2'b10}, r);
        apb(1'b1, `SADC_DATA_OFS, {24'h0, rows[i].code}, r);
      end else
        apb(1'b1, `SADC_CTRL_OFS, {28'h0, rows[i].chan, 2'b01}, r);
      wait_irq(rows[i].mode ? 48 : 400);
      r = 32'h4;
      for (int k = 0; k < 40 && r[2] !== 1'b0; k++)
        apb(1'b0, `SADC_STAT_OFS, 32'h0, r);
      chk(r & (rows[i].mode ? 32'hF : 32'hD),
          {30'h0, rows[i].mode & rows[i].exp[0], 1'b1});
      apb(1'b0, `SADC_DATA_OFS, 32'h0, r);
      chk(r, {24'h0, rows[i].mode ? rows[i].code : rows[i].exp});
      chk(smp_n - m0, rows[i].mode ? 14 : 112);
      d = sup_n - s0;
      chk({31'h0, rows[i].mode ? (d >= 12 && d <= 18)
                               : (d >= 380 && d <= 390)}, 32'h1);
      apb(1'b1, `SADC_IRQ_OFS, 32'h3, r);
      @(negedge clk_i);
      chk({31'h0, irq}, 32'h0);
    end
    // Data write ignored in continuous mode
    apb(1'b1, `SADC_DATA_OFS, 32'h5A, r);
    apb(1'b0, `SADC_DATA_OFS, 32'h0, r);
    chk(r, 32'hA4);
    // Stop in mid-conversion
    apb(1'b1, `SADC_CTRL_OFS, 32'h1, r);
    repeat (100) @(posedge clk_i);
    stop <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk({31'h0, supply}, 32'h0);
    stop <= 1'b0;
    s0 = sup_n;
    repeat (400) @(posedge clk_i);
    chk(sup_n - s0, 32'h0);
    chk({31'h0, irq}, 32'h0);
    apb(1'b0, `SADC_DATA_OFS, 32'h0, r);
    chk(r, 32'h0);
    // Halt between two samples, then resume
    apb(1'b1, `SADC_CTRL_OFS, 32'h5, r);
    repeat (30) @(posedge clk_i);
    halt <= 1'b1;
    repeat (2) @(posedge clk_i);
    m0 = smp_n;
    repeat (200) @(posedge clk_i);
    chk(smp_n - m0, 32'h0);
    chk({31'h0, supply}, 32'h1);
    halt <= 1'b0;
    wait_irq(400);
    apb(1'b1, `SADC_MASK_OFS, 32'h0, r);
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h0);
    apb(1'b1, `SADC_MASK_OFS, 32'h1, r);
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h1);
    apb(1'b1, `SADC_IRQ_OFS, 32'h1, r);
    @(negedge clk_i);
    chk({31'h0, irq}, 32'h0);
    // Unmapped address
    apb(1'b0, 12'h020, 32'h0, r);
    chk({31'h0, perr}, 32'h1);
    chk(r, 32'h0);
    summarize();
  end
endmodule
`default_nettype wire

// ---- sadc_map.svh ----
// Register offsets, fields, reset values and timing counts of the converter
// Contract
// - Continuous mode resolves eight bits, most significant bit first.
// - Single mode does one comparison of input against data-register code.
// - Mode select 0 is continuous conversion, 1 is single comparison.
// - Stop instruction clears the data register to zero.
// - Continuous mode supply on from start until done flag sets.
// - Single mode supply on from start or data write until result stored.
// - HALT suspends conversion, keeps supply on; release resumes it.
// - STOP aborts, initialises, cuts supply; stays idle until restarted.
// - Data register accumulates decisions, or supplies the written code.
// - Decision is 1 when input exceeds DAC voltage, else 0.
// - Decisions go to data bits in continuous, result flag in single.
// - A full conversion takes eight sampling and comparison steps.
// - Sampling lasts 14 core clocks; steps repeat every 48 core clocks.
// - Single result valid within three instructions after the write.
// - With mode select 0, data-register writes are ignored.
// - Four analog channels, one selected per operation.
`ifndef SADC_MAP_SVH
`define SADC_MAP_SVH
// ==========================================================================
// Register byte offsets
`define SADC_CTRL_OFS   12'h000
`define SADC_DATA_OFS   12'h004
`define SADC_STAT_OFS   12'h008
`define SADC_IRQ_OFS    12'h00C
`define SADC_MASK_OFS   12'h010
// ==========================================================================
// Control fields
`define SADC_CTRL_START 0
`define SADC_CTRL_MODE  1
`define SADC_CTRL_CHLO  2
`define SADC_CTRL_CHHI  3
// Status fields
`define SADC_STAT_DONE  0
`define SADC_STAT_CMP   1
`define SADC_STAT_BUSY  2
`define SADC_STAT_SUPP  3
// Event bits
`define SADC_EV_DONE    0
`define SADC_EV_CMP     1
// ==========================================================================
// Reset values and timing
`define SADC_DATA_RST   8'h00
`define SADC_SAMPLE_CC  14
`define SADC_STEP_CC    48
`endif

// ---- sadc_pkg.sv ----
// Types shared by the converter control
package sadc_pkg;
  typedef enum logic [1:0] {
    SADC_IDLE,
    SADC_SAMPLE,
    SADC_SETTLE
  } sadc_state_e;
  typedef struct packed {
    logic       mode;
    logic [1:0] chan;
  } sadc_cfg_s;
endpackage
